/* qpg_top.sv */
// Purpose: Quad pulse width modulator with command register and port C pins.
// Assumes: REF_CLK_I at 20 MHz; RESETN_I asynchronous, active low.
// Notes: Fast count clock is every reference cycle; slow is a 1 us tick.
//
// Notes on behaviour
// - Four channels, each with 24-bit period and duty down counters.
// - Duty spans always off to always on; period 2 gives half clock.
// - Polarity picks active level; inactive level is always its opposite.
// - On start both counters count together and output goes active if duty is not zero.
// - Duty counter stops at zero; output inactive for rest of period.
// - Period counter at one reloads both counters and reasserts active if duty is not zero.
// - Duty value may change while running; used at next reload.
// - Config commands hit one channel; start, stop, reset may hit all.
// - Stop forces inactive, reloads counters, keeps configuration.
// - Reset stops channel and returns pin to its normal direction and data.
// - Pin enable forces the pin to output regardless of direction.
// - Without output gate the pin holds the inactive level.
// - Clock select picks fast or 1 MHz tick for both counters.
// - Start begins all selected channels on the same cycle.
// - Channels zero to three drive port C bits four to seven.
//
// Chosen here: the placing of the registers and the strobed register port.

module qpg_top
  import qpg_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [DATA_W-1:0] RDATA_O,
  input wire logic [DIO_W-1:0] PORTC_I,
  output logic [DIO_W-1:0] PORTC_O,
  output logic [DIO_W-1:0] PORTC_OE_O
);

  // ========================================================================
  // Types and functions
  // ========================================================================
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic [CNT_W-1:0] load_data;
    logic [DIO_W-1:0] dio_data;
    logic [DIO_W-1:0] dio_dir;
    logic [NUM_CH-1:0] gate;
    logic [NUM_CH-1:0] pin_en;
    logic [NUM_CH-1:0] pol;
    logic [NUM_CH-1:0] clksel;
    logic [DIV_W-1:0] div_cnt;
    logic slow_tick;
    logic [DIO_W-1:0] sync1;
    logic [DIO_W-1:0] sync2;
    logic [DIO_W-1:0] sync3;
    logic [DIO_W-1:0] pin_in;
    logic [DIO_W-1:0] port_o;
    logic [DIO_W-1:0] port_oe;
  } qpg_top_state_t;

  // Channel mask from the all flag and the channel number
  function automatic logic [NUM_CH-1:0] chan_mask(input logic all, input logic [1:0] ch);
    logic [NUM_CH-1:0] m;
    m = '0;
    if (all) begin
      m = '1;
    end else begin
      m[ch] = 1'b1;
    end
    return m;
  endfunction : chan_mask

  // Pin level for one channel from polarity, gate and raw wave
  function automatic logic pin_level(input logic pol, input logic gate, input logic wave);
    return (gate && wave) ? pol : ~pol;
  endfunction : pin_level

  qpg_top_state_t st_reg;
  qpg_top_state_t st_next;
  qpg_chan_ctl_t ctl [NUM_CH];
  qpg_chan_sts_t sts [NUM_CH];
  logic [NUM_CH-1:0] wave;
  logic [NUM_CH-1:0] level;
  logic cmd_wr;
  qpg_op_t cmd_op;
  logic [1:0] cmd_ch;
  logic cmd_all;
  logic cmd_arg;
  logic [NUM_CH-1:0] one_mask;
  logic [NUM_CH-1:0] grp_mask;
  logic [NUM_CH-1:0] start_mask;
  logic [NUM_CH-1:0] stop_mask;
  logic [NUM_CH-1:0] clear_mask;

  // ========================================================================
  // Command decode
  // ========================================================================
  // Fields of a write to the command register
  assign cmd_wr = WR_I && (ADDR_I == ADDR_CMD);
  assign cmd_op = qpg_op_t'(WDATA_I[CMD_OP_LSB +: CMD_OP_W]);
  assign cmd_ch = WDATA_I[CMD_CH_LSB +: 2];
  assign cmd_all = WDATA_I[CMD_ALL_BIT];
  assign cmd_arg = WDATA_I[CMD_ARG_BIT];
  assign one_mask = chan_mask(1'b0, cmd_ch);
  assign grp_mask = chan_mask(cmd_all, cmd_ch);
  assign start_mask = (cmd_wr && cmd_op == QPG_OP_START) ? grp_mask : '0;
  assign stop_mask = (cmd_wr && cmd_op == QPG_OP_STOP) ? grp_mask : '0;
  assign clear_mask = (cmd_wr && cmd_op == QPG_OP_RESET) ? grp_mask : '0;

  // Strobes towards each channel
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      ctl[c].start = start_mask[c];
      ctl[c].stop = stop_mask[c];
      ctl[c].clear = clear_mask[c];
      ctl[c].load_per = cmd_wr && (cmd_op == QPG_OP_LOAD) && one_mask[c] && !cmd_arg;
      ctl[c].load_duty = cmd_wr && (cmd_op == QPG_OP_LOAD) && one_mask[c] && cmd_arg;
      ctl[c].value = st_reg.load_data;
    end
  end

  // ========================================================================
  // Channels
  // ========================================================================
  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
      logic tick;
      assign tick = st_reg.clksel[g] ? st_reg.slow_tick : 1'b1;

      qpg_channel u_chan (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESETN_I),
        .tick_i(tick),
        .ctl_i(ctl[g]),
        .sts_o(sts[g])
      );

      assign wave[g] = sts[g].running && sts[g].active;
      assign level[g] = pin_level(st_reg.pol[g], st_reg.gate[g], wave[g]);
    end
  endgenerate

  // ========================================================================
  // Next state
  // ========================================================================
  always_comb begin
    st_next = st_reg;

    // Input synchroniser; a change counts once stages two and three agree
    st_next.sync1 = PORTC_I;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    for (int b = 0; b < DIO_W; b++) begin
      if (st_reg.sync2[b] == st_reg.sync3[b]) begin
        st_next.pin_in[b] = st_reg.sync3[b];
      end
    end

    // Slow count tick divider
    if (st_reg.div_cnt == DIV_W'(SLOW_DIV - 1)) begin
      st_next.div_cnt = '0;
      st_next.slow_tick = 1'b1;
    end else begin
      st_next.div_cnt = st_reg.div_cnt + DIV_W'(1);
      st_next.slow_tick = 1'b0;
    end

    if (start_mask != '0) begin
      st_next.div_cnt = '0;
      st_next.slow_tick = 1'b0;
    end

    // Register writes
    if (WR_I) begin
      unique case (ADDR_I)
        ADDR_LOAD: begin
          st_next.load_data = WDATA_I[CNT_W-1:0];
        end
        ADDR_DIO_DATA: begin
          st_next.dio_data = WDATA_I[DIO_W-1:0];
        end
        ADDR_DIO_DIR: begin
          st_next.dio_dir = WDATA_I[DIO_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Single-channel configuration commands
    if (cmd_wr) begin
      unique case (cmd_op)
        QPG_OP_POL: begin
          st_next.pol[cmd_ch] = cmd_arg;
        end
        QPG_OP_GATE: begin
          st_next.gate[cmd_ch] = cmd_arg;
        end
        QPG_OP_PIN: begin
          st_next.pin_en[cmd_ch] = cmd_arg;
        end
        QPG_OP_CLK: begin
          st_next.clksel[cmd_ch] = cmd_arg;
        end
        default: begin
        end
      endcase
    end

    for (int c = 0; c < NUM_CH; c++) begin
      if (clear_mask[c]) begin
        st_next.gate[c] = 1'b0;
        st_next.pin_en[c] = 1'b0;
        st_next.pol[c] = RST_POL;
        st_next.clksel[c] = RST_CLKSEL;
      end
    end

    // Port C drive; normal direction and data unless a channel owns the bit
    st_next.port_o = st_reg.dio_data;
    st_next.port_oe = st_reg.dio_dir;
    for (int c = 0; c < NUM_CH; c++) begin
      if (st_reg.pin_en[c]) begin
        st_next.port_oe[PWM_PIN_BASE + c] = 1'b1;
        st_next.port_o[PWM_PIN_BASE + c] = level[c];
      end
    end

    // Read data, valid the cycle after the strobe
    st_next.rdata = '0;
    if (RD_I) begin
      if ((ADDR_I & ADDR_CHAN_MASK) == ADDR_CHAN_BASE) begin
        st_next.rdata[CNT_W-1:0] = ADDR_I[2] ? sts[ADDR_I[4:3]].duty_val
                                              : sts[ADDR_I[4:3]].per_val;
      end else begin
        unique case (ADDR_I)
          ADDR_LOAD: begin
            st_next.rdata[CNT_W-1:0] = st_reg.load_data;
          end
          ADDR_STATUS: begin
            for (int c = 0; c < NUM_CH; c++) begin
              st_next.rdata[STS_RUN_LSB + c] = sts[c].running;
              st_next.rdata[STS_LEVEL_LSB + c] = level[c];
            end
            st_next.rdata[STS_GATE_LSB +: NUM_CH] = st_reg.gate;
            st_next.rdata[STS_PIN_LSB +: NUM_CH] = st_reg.pin_en;
            st_next.rdata[STS_POL_LSB +: NUM_CH] = st_reg.pol;
            st_next.rdata[STS_CLK_LSB +: NUM_CH] = st_reg.clksel;
          end
          ADDR_DIO_DATA: begin
            st_next.rdata[DIO_W-1:0] = st_reg.dio_data;
          end
          ADDR_DIO_DIR: begin
            st_next.rdata[DIO_W-1:0] = st_reg.dio_dir;
          end
          ADDR_DIO_IN: begin
            st_next.rdata[DIO_W-1:0] = st_reg.pin_in;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ========================================================================
  // State register
  // ========================================================================
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_reg <= '0;
      st_reg.pol <= {NUM_CH{RST_POL}};
      st_reg.clksel <= {NUM_CH{RST_CLKSEL}};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs from flip-flops
  assign RDATA_O = st_reg.rdata;
  assign PORTC_O = st_reg.port_o;
  assign PORTC_OE_O = st_reg.port_oe;

endmodule : qpg_top

/* qpg_pkg.sv */
// Purpose: Shared constants and types for the quad pulse width modulator.
// Assumes: 20 MHz reference clock; plain register port with 8-bit byte address.
// Notes: Register offsets are byte addresses of aligned 32-bit words.

// ==========================================================================
// Package
// ==========================================================================
package qpg_pkg;

  // ========================================================================
  // Sizes
  // ========================================================================
  localparam int NUM_CH = 4;
  localparam int CNT_W = 24;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DIO_W = 8;
  localparam int PWM_PIN_BASE = 4;       // Channel 0 drives port bit 4

  // ========================================================================
  // Register offsets
  // ========================================================================
  localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_LOAD = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_DIO_DATA = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_DIO_DIR = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_DIO_IN = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_BASE = 8'h20;  // Period at +8*ch, duty at +8*ch+4
  localparam logic [ADDR_W-1:0] ADDR_CHAN_MASK = 8'hE0;

  // ========================================================================
  // Command word fields
  // ========================================================================
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 4;
  localparam int CMD_CH_LSB = 4;
  localparam int CMD_ALL_BIT = 6;
  localparam int CMD_ARG_BIT = 7;

  // Status word fields
  localparam int STS_RUN_LSB = 0;
  localparam int STS_LEVEL_LSB = 4;
  localparam int STS_GATE_LSB = 8;
  localparam int STS_PIN_LSB = 12;
  localparam int STS_POL_LSB = 16;
  localparam int STS_CLK_LSB = 20;

  // Command codes
  typedef enum logic [CMD_OP_W-1:0] {
    QPG_OP_STOP = 4'h0,
    QPG_OP_LOAD = 4'h1,
    QPG_OP_POL = 4'h2,
    QPG_OP_GATE = 4'h3,
    QPG_OP_RESET = 4'h4,
    QPG_OP_PIN = 4'h5,
    QPG_OP_CLK = 4'h6,
    QPG_OP_START = 4'h7
  } qpg_op_t;

  // ========================================================================
  // Timing
  // ========================================================================
  localparam int CLK_PERIOD_NS = 50;
  localparam int SLOW_TICK_NS = 1000;    // 1 MHz count clock
  localparam int SLOW_DIV = SLOW_TICK_NS / CLK_PERIOD_NS;
  localparam int DIV_W = $clog2(SLOW_DIV);

  // ========================================================================
  // Reset values
  // ========================================================================
  localparam logic RST_POL = 1'b1;       // Active high
  localparam logic RST_CLKSEL = 1'b0;    // Fast count clock
  localparam logic [CNT_W-1:0] RST_CNT = 24'h000000;

  // Per-channel command strobes from the register side
  typedef struct packed {
    logic start;
    logic stop;
    logic clear;
    logic load_per;
    logic load_duty;
    logic [CNT_W-1:0] value;
  } qpg_chan_ctl_t;

  // Per-channel status towards the register side
  typedef struct packed {
    logic running;
    logic active;
    logic [CNT_W-1:0] per_val;
    logic [CNT_W-1:0] duty_val;
  } qpg_chan_sts_t;

  // Channel state
  typedef struct packed {
    logic running;
    logic active;
    logic [CNT_W-1:0] per_val;
    logic [CNT_W-1:0] duty_val;
    logic [CNT_W-1:0] per_cnt;
    logic [CNT_W-1:0] duty_cnt;
  } qpg_chan_state_t;

endpackage : qpg_pkg

/* qpg_channel.sv */
// Purpose: One modulator channel: period and duty down counters.
// Assumes: Count tick is a one-cycle enable; commands are one-cycle strobes.
// Notes: Output is the raw active flag; polarity and gating live in the top.

module qpg_channel
  import qpg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire qpg_chan_ctl_t ctl_i,
  output qpg_chan_sts_t sts_o
);

  qpg_chan_state_t st_reg;
  qpg_chan_state_t st_next;

  // ========================================================================
  // Next state
  // ========================================================================
  always_comb begin
    st_next = st_reg;
    if (ctl_i.load_per) begin
      st_next.per_val = ctl_i.value;
    end
    if (ctl_i.load_duty) begin
      st_next.duty_val = ctl_i.value;
    end
    if (ctl_i.clear) begin
      st_next = '0;
    end else if (ctl_i.stop) begin
      st_next.running = 1'b0;
      st_next.active = 1'b0;
      st_next.per_cnt = st_reg.per_val;
      st_next.duty_cnt = st_reg.duty_val;
    end else if (ctl_i.start) begin
      st_next.running = 1'b1;
      st_next.active = (st_reg.duty_val != RST_CNT);
      st_next.per_cnt = st_reg.per_val;
      st_next.duty_cnt = st_reg.duty_val;
    end else if (st_reg.running && tick_i) begin
      if (st_reg.per_cnt <= 24'h000001) begin
        st_next.per_cnt = st_reg.per_val;
        st_next.duty_cnt = st_reg.duty_val;
        st_next.active = (st_reg.duty_val != RST_CNT);
      end else begin
        st_next.per_cnt = st_reg.per_cnt - 24'h000001;
        if (st_reg.duty_cnt != RST_CNT) begin
          st_next.duty_cnt = st_reg.duty_cnt - 24'h000001;
          if (st_reg.duty_cnt == 24'h000001) begin
            st_next.active = 1'b0;
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Status out
  assign sts_o.running = st_reg.running;
  assign sts_o.active = st_reg.active;
  assign sts_o.per_val = st_reg.per_val;
  assign sts_o.duty_val = st_reg.duty_val;

endmodule : qpg_channel

/* qpg_pin_model.sv */
// Purpose: Port C pin model standing in for the wiring outside the block.
// Assumes: Released pins sit at the resistor level; external drivers are static.
// Notes: Device drive wins over an external driver on the same bit.

module qpg_pin_model
  import qpg_pkg::*;
#(
  parameter logic PULL_LEVEL = 1'b0
)
(
  input wire logic [DIO_W-1:0] oe_i,
  input wire logic [DIO_W-1:0] o_i,
  input wire logic [DIO_W-1:0] ext_en_i,
  input wire logic [DIO_W-1:0] ext_i,
  output logic [DIO_W-1:0] pins_o
);
  // ==========================================================================
  // Wire level
  // ==========================================================================
  // driven pin wins
  always_comb begin
    for (int b = 0; b < DIO_W; b++) begin
      if (oe_i[b]) begin
        pins_o[b] = o_i[b];
      end else if (ext_en_i[b]) begin
        pins_o[b] = ext_i[b];
      end else begin
        pins_o[b] = PULL_LEVEL;  // Released, resistor level
      end
    end
  end
endmodule : qpg_pin_model

/* qpg_asserts.sv */
// Purpose: Port level checks for the quad modulator.
// Assumes: Settled pin levels are visible three edges after a command.
// Notes: Tracks direction and data writes to know what released pins show.

module qpg_asserts
  import qpg_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [DATA_W-1:0] RDATA_O,
  input wire logic [DIO_W-1:0] PORTC_I,
  input wire logic [DIO_W-1:0] PORTC_O,
  input wire logic [DIO_W-1:0] PORTC_OE_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);
  logic [DIO_W-1:0] dir_reg;
  logic [DIO_W-1:0] dat_reg;

  // Copies of the normal pin direction and data
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      dir_reg <= '0;
      dat_reg <= '0;
    end else if (WR_I && (ADDR_I == ADDR_DIO_DIR)) begin
      dir_reg <= WDATA_I[DIO_W-1:0];
    end else if (WR_I && (ADDR_I == ADDR_DIO_DATA)) begin
      dat_reg <= WDATA_I[DIO_W-1:0];
    end
  end

  // ==========================================================================
  // Sequences
  // ==========================================================================
  sequence s_op(logic [3:0] op);
    WR_I && (ADDR_I == ADDR_CMD) && (WDATA_I[3:0] == op);
  endsequence
  sequence s_wr(logic [ADDR_W-1:0] a);
    WR_I && (ADDR_I == a);
  endsequence

  // ==========================================================================
  // Register port
  // ==========================================================================
  a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == '0)
    else $error("read data not zero outside read cycle");
  a_unmapped_zero: assert property (RD_I && (ADDR_I == 8'h18) |=> RDATA_O == '0)
    else $error("unmapped read not zero");
  a_cmd_reads_zero: assert property (RD_I && (ADDR_I == ADDR_CMD) |=> RDATA_O == '0)
    else $error("command read not zero");
  a_load_back: assert property (
    s_wr(ADDR_LOAD) ##1 (RD_I && (ADDR_I == ADDR_LOAD)) |=> RDATA_O == {8'h00, $past(WDATA_I[23:0], 2)})
    else $error("load value not read back");

  // ==========================================================================
  // Port C pins
  // ==========================================================================
  a_dir_low: assert property (
    s_wr(ADDR_DIO_DIR) |-> ##3 PORTC_OE_O[3:0] == $past(WDATA_I[3:0], 3))
    else $error("low pin direction wrong");
  a_data_low: assert property (
    s_wr(ADDR_DIO_DATA) |-> ##3 (PORTC_O[3:0] & PORTC_OE_O[3:0]) == ($past(WDATA_I[3:0], 3) & PORTC_OE_O[3:0]))
    else $error("low pin data wrong");
  a_pin_forces_out: assert property (
    s_op(QPG_OP_PIN) ##0 WDATA_I[CMD_ARG_BIT] |-> ##3 PORTC_OE_O[PWM_PIN_BASE + $past(WDATA_I[5:4], 3)])
    else $error("enabled pin not driven");
  a_reset_release: assert property (
    s_op(QPG_OP_RESET) ##0 WDATA_I[CMD_ALL_BIT] |-> ##3 (PORTC_OE_O == dir_reg) && ((PORTC_O & dir_reg) == (dat_reg & dir_reg)))
    else $error("reset did not release pins");
  a_stop_holds: assert property (
    s_op(QPG_OP_STOP) ##0 WDATA_I[CMD_ALL_BIT] |-> ##3 $stable(PORTC_O[7:4]) [*5])
    else $error("stopped outputs still move");
endmodule : qpg_asserts

bind qpg_top qpg_asserts u_asserts (.REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .PORTC_I(PORTC_I),
  .PORTC_O(PORTC_O), .PORTC_OE_O(PORTC_OE_O));

/* qpg_top_tb.sv */
// Purpose: Self-checking bench for the quad modulator.
// Assumes: Pins 0 and 1 are driven from outside; others pull down when released.
// Notes: Waveforms are checked cycle by cycle and by high counts per window.

module qpg_top_tb
  import qpg_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, wr, rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [DIO_W-1:0] pc_in, pc_o, pc_oe;
  logic [DIO_W-1:0] ext_en = 8'h03;
  logic [DIO_W-1:0] ext_val = 8'h02;
  logic [CNT_W-1:0] per_v [NUM_CH] = '{24'h5, 24'h2, 24'h3, 24'h2};
  logic [CNT_W-1:0] dut_v [NUM_CH] = '{24'h2, 24'h1, 24'h0, 24'h2};
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int hi;

  qpg_top dut (.REF_CLK_I(clk), .RESETN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .PORTC_I(pc_in), .PORTC_O(pc_o), .PORTC_OE_O(pc_oe));
  qpg_pin_model pins (.oe_i(pc_oe), .o_i(pc_o), .ext_en_i(ext_en), .ext_i(ext_val), .pins_o(pc_in));

  // ==========================================================================
  // Clock and watchdog
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      test_done();
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic test_done();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Write strobe stays up so writes may follow back to back
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr <= a;
    wdata <= d;
    rd <= 1'b0;
    wr <= 1'b1;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] m,
                        input string name);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(name, e & m, rdata & m);
    @(posedge clk);
  endtask : rd_reg
  task automatic cycles(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : cycles
  function automatic logic [DATA_W-1:0] cmdw(input qpg_op_t op, input int ch, input logic all, input logic arg);
    return {24'h0, arg, all, 2'(ch), op};
  endfunction : cmdw
  task automatic load(input int ch, input logic arg, input logic [CNT_W-1:0] v);
    wr_reg(ADDR_LOAD, DATA_W'(v));
    wr_reg(ADDR_CMD, cmdw(QPG_OP_LOAD, ch, 1'b0, arg));
  endtask : load
  task automatic count_hi(input int b, input int n);
    hi = 0;
    repeat (n) begin
      @(negedge clk);
      hi += int'(pc_o[b]);
      @(posedge clk);
    end
  endtask : count_hi

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_reg(ADDR_STATUS, 32'h000F0000, 32'hFFFFFFFF, "status");
    rd_reg(8'h18, 32'h0, 32'hFFFFFFFF, "unmapped");
    rd_reg(ADDR_CMD, 32'h0, 32'hFFFFFFFF, "cmd");
    wr_reg(ADDR_LOAD, 32'hFFFFFFFF);
    rd_reg(ADDR_LOAD, 32'h00FFFFFF, 32'hFFFFFFFF, "load");
    // Program every channel and read back
    for (int c = 0; c < NUM_CH; c++) begin
      load(c, 1'b0, per_v[c]);
      load(c, 1'b1, dut_v[c]);
    end
    for (int c = 0; c < NUM_CH; c++) begin
      rd_reg(ADDR_CHAN_BASE + ADDR_W'(8 * c), DATA_W'(per_v[c]), 32'hFFFFFFFF, "period");
      rd_reg(ADDR_CHAN_BASE + ADDR_W'(8 * c + 4), DATA_W'(dut_v[c]), 32'hFFFFFFFF, "duty");
    end
    // Normal pin use, then take pins over with gate off
    wr_reg(ADDR_DIO_DIR, 32'h8C);
    wr_reg(ADDR_DIO_DATA, 32'h85);
    cycles(10);
    rd_reg(ADDR_DIO_IN, 32'h86, 32'hFF, "dio_in");
    wr_reg(ADDR_CMD, cmdw(QPG_OP_POL, 1, 1'b0, 1'b0));
    for (int c = 0; c < NUM_CH; c++) wr_reg(ADDR_CMD, cmdw(QPG_OP_PIN, c, 1'b0, 1'b1));
    cycles(4);
    chk("pin_oe", 32'hFC, DATA_W'(pc_oe));
    chk("gated", 32'h2, DATA_W'(pc_o[7:4]));
    for (int c = 0; c < NUM_CH; c++) wr_reg(ADDR_CMD, cmdw(QPG_OP_GATE, c, 1'b0, 1'b1));
    wr_reg(ADDR_CMD, cmdw(QPG_OP_START, 0, 1'b1, 1'b0));
    // Pin shows phase zero from the first edge after the start edge
    cycles(1);
    // Aligned waveforms of all four channels
    for (int k = 0; k < 12; k++) begin
      @(negedge clk);
      chk("wave", {28'h0, 2'b10, ~((k % 2) == 0), ((k % 5) < 2)}, DATA_W'(pc_o[7:4]));
      @(posedge clk);
    end
    rd_reg(ADDR_STATUS, 32'hF, 32'hF, "running");
    load(0, 1'b1, 24'h4);
    cycles(12);
    count_hi(4, 5);
    chk("duty_new", 32'h4, DATA_W'(hi));
    // Single stop keeps configuration
    wr_reg(ADDR_CMD, cmdw(QPG_OP_STOP, 0, 1'b0, 1'b0));
    cycles(4);
    rd_reg(ADDR_STATUS, 32'hE, 32'hF, "stop_one");
    chk("stop_pin", 32'h0, DATA_W'(pc_o[4]));
    rd_reg(ADDR_CHAN_BASE, 32'h5, 32'hFFFFFFFF, "kept");
    // Slow count clock restart begins active
    wr_reg(ADDR_CMD, cmdw(QPG_OP_CLK, 0, 1'b0, 1'b1));
    wr_reg(ADDR_CMD, cmdw(QPG_OP_START, 0, 1'b0, 1'b0));
    cycles(2);
    @(negedge clk);
    chk("restart", 32'h1, DATA_W'(pc_o[4]));
    @(posedge clk);
    count_hi(4, 5 * SLOW_DIV);
    chk("slow", DATA_W'(4 * SLOW_DIV), DATA_W'(hi));
    // Stop all, then reset all
    wr_reg(ADDR_CMD, cmdw(QPG_OP_STOP, 0, 1'b1, 1'b0));
    cycles(10);
    rd_reg(ADDR_STATUS, 32'h0, 32'hF, "stop_all");
    wr_reg(ADDR_CMD, cmdw(QPG_OP_RESET, 0, 1'b1, 1'b0));
    cycles(10);
    chk("rel_oe", 32'h8C, DATA_W'(pc_oe));
    chk("rel_data", 32'h84, DATA_W'(pc_o & pc_oe));
    rd_reg(ADDR_STATUS, 32'h000F0000, 32'hFFFFFFFF, "cleared");
    rd_reg(ADDR_DIO_IN, 32'h86, 32'hFF, "rel_in");
    test_done();
  end
endmodule : qpg_top_tb
